// ===== verilog/ihc_target.sv
// I2C register target: link logic on LINK_CLK_I, register port on CLK_I.
// Assumes a host that drives SCL and a register file answering in one cycle.
`timescale 1ns/1ps
`include "ihc_defines.svh"
module ihc_target
    import ihc_pkg::*;
(
    // Register-side clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Link sampling clock
    input wire logic LINK_CLK_I,
    // Bus
    ihc_if.dev BUS,
    // Configuration
    input wire logic EN_I,
    input wire logic WR_MODE_I,
    // Register port
    output logic REG_WE_O,
    output logic REG_RE_O,
    output logic [7:0] REG_ADDR_O,
    output logic [7:0] REG_WDATA_O,
    input wire logic [7:0] REG_RDATA_I,
    input wire logic REG_HIT_I
);

    // Link-domain reset and level synchronisers
    logic lrst_s1_r;
    logic lrst_b_r;
    logic en_s1_r;
    logic en_s2_r;
    logic mode_s1_r;
    logic mode_s2_r;
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_f_r;
    logic [1:0] pin_p_r;
    logic [3:0] flt_cnt_r [2];

    always_ff @(posedge LINK_CLK_I)
    begin
        lrst_s1_r <= RST_B_I;
        lrst_b_r <= lrst_s1_r;
        en_s1_r <= EN_I;
        en_s2_r <= en_s1_r;
        mode_s1_r <= WR_MODE_I;
        mode_s2_r <= mode_s1_r;
        pin_s1_r <= {BUS.sda, BUS.scl};
        pin_s2_r <= pin_s1_r;
    end

    // Deglitch: a line changes only after holding for the filter length
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_flt
            logic [3:0] cnt_nxt;
            logic f_nxt;
            always_comb
            begin
                cnt_nxt = 4'h0;
                f_nxt = pin_f_r[gi];
                if (pin_s2_r[gi] != pin_f_r[gi])
                begin
                    cnt_nxt = 4'(flt_cnt_r[gi] + 4'h1);
                    if (flt_cnt_r[gi] == `IHC_FLT_LEN)
                    begin
                        f_nxt = pin_s2_r[gi];
                        cnt_nxt = 4'h0;
                    end
                end
            end
            always_ff @(posedge LINK_CLK_I)
            begin
                if (!lrst_b_r)
                begin
                    flt_cnt_r[gi] <= 4'h0;
                    pin_f_r[gi] <= 1'b1;
                    pin_p_r[gi] <= 1'b1;
                end
                else
                begin
                    flt_cnt_r[gi] <= cnt_nxt;
                    pin_f_r[gi] <= f_nxt;
                    pin_p_r[gi] <= pin_f_r[gi];
                end
            end
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_f = pin_f_r[0];
    assign sda_f = pin_f_r[1];
    assign scl_rise = scl_f & ~pin_p_r[0];
    assign scl_fall = ~scl_f & pin_p_r[0];
    assign start_c = scl_f & pin_p_r[0] & pin_p_r[1] & ~sda_f;
    assign stop_c = scl_f & pin_p_r[0] & ~pin_p_r[1] & sda_f;

    // Handshake answer back from the register domain
    logic ack_tgl_r;
    logic [7:0] rdata_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_s3_r;
    logic ack_seen;
    always_ff @(posedge LINK_CLK_I)
    begin
        ack_s1_r <= ack_tgl_r;
        ack_s2_r <= ack_s1_r;
        ack_s3_r <= ack_s2_r;
    end
    assign ack_seen = ack_s2_r ^ ack_s3_r;

    // Protocol engine
    ihc_dstate_t st_r, st_nxt;
    ihc_kind_t kind_r, kind_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rd_r, rd_nxt;
    logic hack_r, hack_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] txb_r, txb_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic req_we_r, req_we_nxt;
    logic [7:0] req_addr_r, req_addr_nxt;
    logic [7:0] req_wd_r, req_wd_nxt;

    always_comb
    begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        ptr_nxt = ptr_r;
        rd_nxt = rd_r;
        hack_nxt = hack_r;
        oe_nxt = oe_r;
        txb_nxt = ack_seen ? rdata_r : txb_r;
        req_tgl_nxt = req_tgl_r;
        req_we_nxt = req_we_r;
        req_addr_nxt = req_addr_r;
        req_wd_nxt = req_wd_r;
        if (stop_c || !en_s2_r)
        begin
            st_nxt = DS_IDLE;
            oe_nxt = 1'b0;
        end
        else if (start_c)
        begin
            st_nxt = DS_RX;
            kind_nxt = BK_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                DS_IDLE, DS_WAIT:
                begin
                    oe_nxt = 1'b0;
                end
                DS_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_nxt = {sh_r[6:0], sda_f};
                        cnt_nxt = 4'(cnt_r + 4'h1);
                    end
                    else if (scl_fall && cnt_r == `IHC_BITS)
                    begin
                        st_nxt = DS_ACK;
                        oe_nxt = 1'b1;
                        unique case (kind_r)
                            BK_ADDR:
                            begin
                                if (sh_r == `IHC_ADDR_RD)
                                begin
                                    rd_nxt = 1'b1;
                                    req_tgl_nxt = ~req_tgl_r;
                                    req_we_nxt = 1'b0;
                                    req_addr_nxt = ptr_r;
                                end
                                else if (sh_r == `IHC_ADDR_WR)
                                begin
                                    rd_nxt = 1'b0;
                                    kind_nxt = BK_REG;
                                end
                                else
                                begin
                                    st_nxt = DS_WAIT;
                                    oe_nxt = 1'b0;
                                end
                            end
                            BK_REG:
                            begin
                                ptr_nxt = sh_r;
                                kind_nxt = BK_DATA;
                            end
                            default:
                            begin
                                req_tgl_nxt = ~req_tgl_r;
                                req_we_nxt = 1'b1;
                                req_addr_nxt = ptr_r;
                                req_wd_nxt = sh_r;
                                if (mode_s2_r)
                                begin
                                    kind_nxt = BK_REG;
                                end
                                else
                                begin
                                    ptr_nxt = 8'(ptr_r + 8'h01);
                                end
                            end
                        endcase
                    end
                end
                DS_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (rd_r)
                        begin
                            st_nxt = DS_TX;
                            sh_nxt = txb_nxt;
                            oe_nxt = ~txb_nxt[7];
                        end
                        else
                        begin
                            st_nxt = DS_RX;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                DS_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_r == `IHC_LAST_TX_BIT)
                        begin
                            st_nxt = DS_HACK;
                            oe_nxt = 1'b0;
                            req_tgl_nxt = ~req_tgl_r;
                            req_we_nxt = 1'b0;
                            // Next byte prefetched a whole bit ahead
                            ptr_nxt = mode_s2_r ? ptr_r : 8'(ptr_r + 8'h01);
                            req_addr_nxt = ptr_nxt;
                        end
                        else
                        begin
                            cnt_nxt = 4'(cnt_r + 4'h1);
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                DS_HACK:
                begin
                    if (scl_rise)
                    begin
                        hack_nxt = ~sda_f;
                    end
                    else if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (hack_r)
                        begin
                            st_nxt = DS_TX;
                            sh_nxt = txb_nxt;
                            oe_nxt = ~txb_nxt[7];
                        end
                        else
                        begin
                            st_nxt = DS_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge LINK_CLK_I)
    begin
        if (!lrst_b_r)
        begin
            st_r <= DS_IDLE;
            kind_r <= BK_ADDR;
            sh_r <= 8'h00;
            cnt_r <= 4'h0;
            ptr_r <= 8'h00;
            rd_r <= 1'b0;
            hack_r <= 1'b0;
            oe_r <= 1'b0;
            txb_r <= 8'h00;
            req_tgl_r <= 1'b0;
            req_we_r <= 1'b0;
            req_addr_r <= 8'h00;
            req_wd_r <= 8'h00;
        end
        else
        begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            ptr_r <= ptr_nxt;
            rd_r <= rd_nxt;
            hack_r <= hack_nxt;
            oe_r <= oe_nxt;
            txb_r <= txb_nxt;
            req_tgl_r <= req_tgl_nxt;
            req_we_r <= req_we_nxt;
            req_addr_r <= req_addr_nxt;
            req_wd_r <= req_wd_nxt;
        end
    end

    // Only ever pulls SDA low; SCL is never driven
    assign BUS.dev_sda_o = 1'b0;
    assign BUS.dev_sda_oe = oe_r;
    assign BUS.dev_scl_o = 1'b0;
    assign BUS.dev_scl_oe = 1'b0;

    // Register domain: request toggle in, access, answer toggle out
    logic rq_s1_r;
    logic rq_s2_r;
    logic rq_s3_r;
    logic pend_r, pend_nxt;
    logic we_nxt;
    logic re_nxt;
    logic [7:0] addr_nxt;
    logic [7:0] wd_nxt;
    logic ack_tgl_nxt;
    logic [7:0] rdata_nxt;

    always_ff @(posedge CLK_I)
    begin
        rq_s1_r <= req_tgl_r;
        rq_s2_r <= rq_s1_r;
        rq_s3_r <= rq_s2_r;
    end

    always_comb
    begin
        we_nxt = 1'b0;
        re_nxt = 1'b0;
        addr_nxt = REG_ADDR_O;
        wd_nxt = REG_WDATA_O;
        pend_nxt = 1'b0;
        ack_tgl_nxt = ack_tgl_r;
        rdata_nxt = rdata_r;
        // Request fields held steady by the link side across the handshake
        if (rq_s2_r ^ rq_s3_r)
        begin
            we_nxt = req_we_r;
            re_nxt = ~req_we_r;
            addr_nxt = req_addr_r;
            wd_nxt = req_wd_r;
            pend_nxt = 1'b1;
        end
        if (pend_r)
        begin
            rdata_nxt = REG_HIT_I ? REG_RDATA_I : 8'h00;
            ack_tgl_nxt = ~ack_tgl_r;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            REG_WE_O <= 1'b0;
            REG_RE_O <= 1'b0;
            REG_ADDR_O <= 8'h00;
            REG_WDATA_O <= 8'h00;
            pend_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            REG_WE_O <= we_nxt;
            REG_RE_O <= re_nxt;
            REG_ADDR_O <= addr_nxt;
            REG_WDATA_O <= wd_nxt;
            pend_r <= pend_nxt;
            ack_tgl_r <= ack_tgl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

endmodule // ihc_target

// ===== verilog/ihc_defines.svh
// Constants of the I2C register target and its host controller.
// Assumes inclusion by both ends; holds definitions only.
// Functional notes
// - Answer target address 0x4A, bytes 0x94/0x95
// - Accept up to 1 MHz, never stretch
// - SCL rate free, unrelated to internal clock
// - Target only, never drives START/STOP/SCL
// - Lines only pulled low or released
// - SDA changes at SCL low, sampled high
// - Eight bits per byte, MSB first
// - START/STOP detected while SCL high
// - Acknowledge own address when enabled
// - Single write: addr, reg, data, all acknowledged
// - Host writes pointer, restarts to read, NAKs
// - Mode 0: each byte sent advances read pointer, ACK or NAK
// - Missing register reads as zero
// - Host repeats same address after restart
// - Mode 0: writes auto-increment until STOP
// - Mode 1: alternating address and data pairs
// - STOP mid-message aborts to idle, START restarts at the address byte
// - Mode 1 reads and writes non-incrementing
`ifndef IHC_DEFINES_SVH
`define IHC_DEFINES_SVH

`define IHC_ADDR_WR 8'h94
`define IHC_ADDR_RD 8'h95
`define IHC_BITS 4'h8
`define IHC_LAST_TX_BIT 4'h7
`define IHC_FLT_LEN 4'h8
`define IHC_CLK_HZ 32'h0262_5A00
`define IHC_SCL_HZ 32'h000F_4240
`define IHC_QTR_CYC 8'((`IHC_CLK_HZ) / (4 * (`IHC_SCL_HZ)))
`define IHC_HOST_BITS 4'h9

`endif

// ===== verilog/ihc_pkg.sv
// Types shared by both ends of the I2C register link.
// Assumes ihc_defines.svh supplies the numeric constants.
package ihc_pkg;
    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_HACK, DS_WAIT} ihc_dstate_t;
    typedef enum logic [1:0] {BK_ADDR, BK_REG, BK_DATA} ihc_kind_t;
    typedef enum logic [1:0] {OP_START, OP_WRBYTE, OP_RDBYTE, OP_STOP} ihc_op_t;
    typedef enum logic {HS_IDLE, HS_RUN} ihc_hstate_t;
endpackage

// ===== verilog/ihc_if.sv
// Two-wire bus joining the host controller and the register target.
// Resolves the open-drain wires from each party's output and enable.
`timescale 1ns/1ps
interface ihc_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // Wired-AND: pull-ups give the high level
    assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
        output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
        output host_sda_o, output host_sda_oe);
endinterface // ihc_if

// ===== verilog/ihc_host.sv
// I2C host controller: byte-level command port, SCL made by a divider.
// Assumes a target that never stretches SCL, so SCL is not read back.
`timescale 1ns/1ps
`include "ihc_defines.svh"
module ihc_host
    import ihc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Bus
    ihc_if.host BUS,
    // Command
    input wire logic CMD_VALID_I,
    input wire logic [1:0] CMD_OP_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic CMD_NAK_I,
    output logic CMD_READY_O,
    // Result
    output logic DONE_O,
    output logic [7:0] DONE_DATA_O,
    output logic DONE_NAK_O
);

    // Per quarter of a bit: {SCL low, SDA low}
    function automatic logic [1:0] lines(input ihc_op_t op, input logic [1:0] q,
        input logic b);
        logic [1:0] r;
        r = 2'b00;
        unique case (op)
            OP_START: r = {(q == 2'd0) || (q == 2'd3), q[1]};
            OP_STOP: r = {q == 2'd0, ~q[1]};
            default: r = {(q == 2'd0) || (q == 2'd3), ~b};
        endcase
        return r;
    endfunction

    logic sda_s1_r;
    logic sda_s2_r;
    always_ff @(posedge CLK_I)
    begin
        sda_s1_r <= BUS.sda;
        sda_s2_r <= sda_s1_r;
    end

    ihc_hstate_t st_r, st_nxt;
    ihc_op_t op_r, op_nxt;
    logic [7:0] div_r, div_nxt;
    logic [1:0] q_r, q_nxt;
    logic [3:0] bi_r, bi_nxt;
    logic [8:0] sh_r, sh_nxt;
    logic [8:0] rx_r, rx_nxt;
    logic scl_low_r, scl_low_nxt;
    logic sda_low_r, sda_low_nxt;
    logic ready_nxt;
    logic done_nxt;
    logic [7:0] dd_nxt;
    logic dn_nxt;
    logic tick;
    logic last;

    assign tick = div_r == 8'(`IHC_QTR_CYC - 8'h01);
    assign last = (op_r == OP_START) || (op_r == OP_STOP) || (bi_r == 4'(`IHC_HOST_BITS - 4'h1));

    always_comb
    begin
        st_nxt = st_r;
        op_nxt = op_r;
        div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
        q_nxt = q_r;
        bi_nxt = bi_r;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        scl_low_nxt = scl_low_r;
        sda_low_nxt = sda_low_r;
        ready_nxt = CMD_READY_O;
        done_nxt = 1'b0;
        dd_nxt = DONE_DATA_O;
        dn_nxt = DONE_NAK_O;
        unique case (st_r)
            HS_IDLE:
            begin
                if (CMD_VALID_I && CMD_READY_O)
                begin
                    st_nxt = HS_RUN;
                    op_nxt = ihc_op_t'(CMD_OP_I);
                    // Reads release data bits and send the chosen ACK/NAK
                    sh_nxt = (ihc_op_t'(CMD_OP_I) == OP_RDBYTE) ?
                        {8'hFF, CMD_NAK_I} : {CMD_DATA_I, 1'b1};
                    q_nxt = 2'd0;
                    bi_nxt = 4'h0;
                    div_nxt = 8'h00;
                    ready_nxt = 1'b0;
                    {scl_low_nxt, sda_low_nxt} = lines(ihc_op_t'(CMD_OP_I), 2'd0,
                        sh_nxt[8]);
                end
            end
            HS_RUN:
            begin
                if (tick)
                begin
                    if (q_r == 2'd2)
                    begin
                        rx_nxt = {rx_r[7:0], sda_s2_r};
                    end
                    if (q_r == 2'd3)
                    begin
                        if (last)
                        begin
                            st_nxt = HS_IDLE;
                            ready_nxt = 1'b1;
                            done_nxt = 1'b1;
                            dd_nxt = rx_r[8:1];
                            dn_nxt = rx_r[0];
                        end
                        else
                        begin
                            q_nxt = 2'd0;
                            bi_nxt = 4'(bi_r + 4'h1);
                            sh_nxt = {sh_r[7:0], 1'b1};
                            {scl_low_nxt, sda_low_nxt} = lines(op_r, 2'd0, sh_r[7]);
                        end
                    end
                    else
                    begin
                        q_nxt = 2'(q_r + 2'd1);
                        {scl_low_nxt, sda_low_nxt} = lines(op_r, q_nxt, sh_r[8]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            st_r <= HS_IDLE;
            op_r <= OP_STOP;
            div_r <= 8'h00;
            q_r <= 2'd0;
            bi_r <= 4'h0;
            sh_r <= 9'h000;
            rx_r <= 9'h000;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            CMD_READY_O <= 1'b1;
            DONE_O <= 1'b0;
            DONE_DATA_O <= 8'h00;
            DONE_NAK_O <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            div_r <= div_nxt;
            q_r <= q_nxt;
            bi_r <= bi_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            scl_low_r <= scl_low_nxt;
            sda_low_r <= sda_low_nxt;
            CMD_READY_O <= ready_nxt;
            DONE_O <= done_nxt;
            DONE_DATA_O <= dd_nxt;
            DONE_NAK_O <= dn_nxt;
        end
    end

    // Pull low or release only
    assign BUS.host_scl_o = 1'b0;
    assign BUS.host_scl_oe = scl_low_r;
    assign BUS.host_sda_o = 1'b0;
    assign BUS.host_sda_oe = sda_low_r;

endmodule // ihc_host

// ===== dv/ihc_assertions.sv
// Bus checker for the host controller and register target link.
// Assumes the bus is sampled on the host clock, which makes SCL.
`timescale 1ns/1ps
module ihc_assertions (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Bus lines, drivers and target enable
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic en_i,
    input wire logic host_sda_o,
    input wire logic host_sda_oe
);
    logic scl_q_r, sda_q_r, first_r, sel_r, rd_r, first_nxt, sel_nxt, rd_nxt;
    logic start_w, stop_w, rise_w, slot_w, hit_w;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] byte_r, byte_nxt;
    always_comb
    begin
        start_w = scl && scl_q_r && sda_q_r && !sda;
        stop_w = scl && scl_q_r && !sda_q_r && sda;
        rise_w = scl && !scl_q_r;
        slot_w = rise_w && (cnt_r == 4'h8);
        hit_w = (byte_r == 8'h94) || (byte_r == 8'h95);
        cnt_nxt = cnt_r;
        byte_nxt = byte_r;
        first_nxt = first_r;
        sel_nxt = sel_r;
        rd_nxt = rd_r;
        // Any condition restarts framing, even mid-byte
        if (start_w || stop_w)
        begin
            cnt_nxt = 4'h0;
            first_nxt = start_w;
            sel_nxt = 1'b0;
            rd_nxt = 1'b0;
        end
        else if (slot_w)
        begin
            cnt_nxt = 4'h0;
            first_nxt = 1'b0;
            if (first_r)
            begin
                sel_nxt = hit_w && !sda;
                rd_nxt = hit_w && !sda && byte_r[0];
            end
        end
        else if (rise_w)
        begin
            cnt_nxt = cnt_r + 4'h1;
            byte_nxt = {byte_r[6:0], sda};
        end
    end
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            {first_r, sel_r, rd_r, cnt_r, byte_r} <= '0;
        end
        else
        begin
            scl_q_r <= scl;
            sda_q_r <= sda;
            {first_r, sel_r, rd_r, cnt_r, byte_r} <=
                {first_nxt, sel_nxt, rd_nxt, cnt_nxt, byte_nxt};
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_ack_low;
        dev_sda_oe && !scl;
    endsequence
    sequence s_ack_high;
        (dev_sda_oe && scl) [*8];
    endsequence
    property p_ack_held;
        $rose(dev_sda_oe) && !rd_r |-> s_ack_low ##[0:40] s_ack_high;
    endproperty
    AST_NO_SCL_DRIVE: assert property (dev_scl_oe == 1'b0)
        else $error("target drove SCL");
    AST_PULL_LOW: assert property (!(dev_sda_oe && dev_sda_o)
        && !(host_sda_oe && host_sda_o))
        else $error("SDA driven high");
    AST_WIRED_AND: assert property (sda == !(dev_sda_oe || host_sda_oe))
        else $error("SDA level wrong");
    AST_DEV_EDGE: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("target SDA moved with SCL high");
    AST_ADDR_ACK: assert property (slot_w && first_r && hit_w && en_i |-> !sda)
        else $error("own address not acknowledged");
    AST_ADDR_IGNORE: assert property (slot_w && first_r && !(hit_w && en_i) |-> sda)
        else $error("foreign address acknowledged");
    AST_BYTE_ACK: assert property (slot_w && sel_r && !rd_r |-> !sda)
        else $error("written byte not acknowledged");
    AST_READ_RELEASE: assert property (slot_w && rd_r |-> !dev_sda_oe)
        else $error("target held SDA in host ack slot");
    AST_ACK_HELD: assert property (p_ack_held)
        else $error("acknowledge not held over SCL high");
endmodule // ihc_assertions

// ===== dv/testbench.sv
// Testbench joining host controller and register target on one bus.
// Assumes the target sees a register file modelled here; 0x80 and up absent.
`timescale 1ns/1ps
module testbench
    import ihc_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_mode = 1'b0;
    logic en = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nak = 1'b0;
    logic cmd_ready, done, done_nak, reg_we, reg_re;
    logic [7:0] done_data, reg_addr, reg_wdata;
    logic [7:0] mem [256];
    int failures = 0;
    int tests_run = 0;
    int reads = 0;
    always #12.5 clk = ~clk;
    initial #0.7 forever #3 link_clk = ~link_clk;
    ihc_if bus_if ();
    ihc_target ihc_target_i (.CLK_I(clk), .RST_B_I(rst_b), .LINK_CLK_I(link_clk),
        .BUS(bus_if.dev), .EN_I(en), .WR_MODE_I(wr_mode), .REG_WE_O(reg_we),
        .REG_RE_O(reg_re), .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata),
        .REG_RDATA_I(mem[reg_addr]), .REG_HIT_I(reg_addr < 8'h80));
    ihc_host ihc_host_i (.CLK_I(clk), .RST_B_I(rst_b), .BUS(bus_if.host),
        .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_DATA_I(cmd_data),
        .CMD_NAK_I(cmd_nak), .CMD_READY_O(cmd_ready), .DONE_O(done),
        .DONE_DATA_O(done_data), .DONE_NAK_O(done_nak));
    ihc_assertions ihc_assertions_i (.CLK_I(clk), .RST_B_I(rst_b), .scl(bus_if.scl),
        .sda(bus_if.sda), .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_o(bus_if.dev_sda_o),
        .dev_sda_oe(bus_if.dev_sda_oe), .en_i(en), .host_sda_o(bus_if.host_sda_o),
        .host_sda_oe(bus_if.host_sda_oe));
    always @(posedge clk) if (reg_we === 1'b1) mem[reg_addr] <= reg_wdata;
    always @(posedge clk) if (reg_re === 1'b1) reads <= reads + 1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Entered just after an edge with the host ready
    task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic n);
        int k;
        k = 0;
        cmd_op = op;
        cmd_data = d;
        cmd_nak = n;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        check({7'h00, cmd_ready}, 8'h00);
        while (done !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            #1 k++;
        end
        check({6'h00, cmd_ready, done}, 8'h03);
    endtask
    task automatic wbyte(input logic [7:0] d, input logic nak);
        cmd(OP_WRBYTE, d, 1'b0);
        check({7'h00, done_nak}, {7'h00, nak});
    endtask
    task automatic wmsg(input logic [7:0] q[$]);
        cmd(OP_START, 8'h00, 1'b0);
        foreach (q[i]) wbyte(q[i], 1'b0);
        cmd(OP_STOP, 8'h00, 1'b0);
    endtask
    task automatic rmsg(input logic [7:0] ptr, input logic [7:0] exp[$]);
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h94, 1'b0);
        wbyte(ptr, 1'b0);
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h95, 1'b0);
        foreach (exp[i])
        begin
            cmd(OP_RDBYTE, 8'h00, i == exp.size() - 1);
            check(done_data, exp[i]);
        end
        cmd(OP_STOP, 8'h00, 1'b0);
    endtask
    task automatic stop_test();
        $display("%0d mismatches in %0d checks", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(~i);
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        wmsg('{8'h94, 8'h10, 8'hA5, 8'h3C, 8'h96});
        check(mem[8'h10], 8'hA5);
        check(mem[8'h12], 8'h96);
        rmsg(8'h10, '{8'hA5, 8'h3C, 8'h96});
        check(8'(reads), 8'h04);
        rmsg(8'h7F, '{8'h80, 8'h00});
        // Unshifted and neighbouring addresses must be ignored
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h4A, 1'b1);
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h96, 1'b1);
        // Disabled target must ignore even its own address
        en = 1'b0;
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h94, 1'b1);
        cmd(OP_STOP, 8'h00, 1'b0);
        en = 1'b1;
        wr_mode = 1'b1;
        wmsg('{8'h94, 8'h20, 8'h11, 8'h05, 8'h22, 8'h30, 8'h33});
        check(mem[8'h20], 8'h11);
        check(mem[8'h05], 8'h22);
        check(mem[8'h21], 8'hDE);
        rmsg(8'h20, '{8'h11, 8'h11});
        // Without the restart the address byte would land at 0x40
        cmd(OP_START, 8'h00, 1'b0);
        wbyte(8'h94, 1'b0);
        wbyte(8'h40, 1'b0);
        wmsg('{8'h94, 8'h41, 8'h77});
        check(mem[8'h40], 8'hBF);
        check(mem[8'h41], 8'h77);
        stop_test();
    end
    initial
    begin
        #2_000_000;
        failures++;
        stop_test();
    end
endmodule // testbench
